/* include/wud_pkg.sv */
// Shared constants for the wake-up interrupt detector
package wud_pkg;

    // ************************************************
    // Geometry
    // ************************************************
    localparam int NUM_LINES = 8;
    localparam int MASK_BITS = 7;
    localparam int ADDR_W    = 10;
    localparam int IDX_W     = 8;
    localparam int REG_W     = 8;

    // ************************************************
    // Register indices (byte address is four times these)
    // ************************************************
    localparam logic [IDX_W-1:0] IDX_INT_MASK_FIVE = 8'hea;
    localparam logic [IDX_W-1:0] IDX_FLAG_CLEAR    = 8'heb;
    localparam logic [IDX_W-1:0] IDX_REQ_FLAGS     = 8'hec;
    localparam logic [IDX_W-1:0] IDX_DETECT_MODE   = 8'hed;
    localparam logic [IDX_W-1:0] IDX_EDGE_DIR      = 8'hee;
    localparam logic [IDX_W-1:0] IDX_INPUT_ENABLE  = 8'hef;

    // ************************************************
    // Reset values
    // ************************************************
    localparam logic [MASK_BITS-1:0] RST_INT_MASK_FIVE = 7'h7f;
    localparam logic [REG_W-1:0]     RST_REQ_FLAGS     = 8'h00;
    localparam logic [REG_W-1:0]     RST_DETECT_MODE   = 8'h00;
    localparam logic [REG_W-1:0]     RST_EDGE_DIR      = 8'h00;
    localparam logic [REG_W-1:0]     RST_INPUT_ENABLE  = 8'h00;

    // ************************************************
    // Bus encodings
    // ************************************************
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic       HRESP_OKAY    = 1'h0;

    // Word-aligned byte address to register index; misaligned maps to none
    function automatic logic [IDX_W:0] wud_index(input logic [ADDR_W-1:0] addr);
        wud_index = {addr[1:0] == 2'h0, addr[ADDR_W-1:2]};
    endfunction

endpackage

/* logic/wud_edge_detect.sv */
// Per-line transition detector with mode, direction and enable
`timescale 1ns/1ps
module wud_edge_detect
    import wud_pkg::*;
#(
    parameter int N = NUM_LINES
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // Lines and configuration
    input  wire logic [N-1:0] lineIn,
    input  wire logic [N-1:0] singleMode,
    input  wire logic [N-1:0] risingSel,
    input  wire logic [N-1:0] lineEnable,
    // Results
    output logic      [N-1:0] rise,
    output logic      [N-1:0] fall,
    output logic      [N-1:0] hit
);

    logic [N-1:0] prevLine;

    // Reset loads the live level so a line already high is no edge
    always_ff @(posedge clk) begin
        if (rst) begin
            prevLine <= lineIn;
        end else begin
            prevLine <= lineIn;
        end
    end

    assign rise = lineIn & ~prevLine;
    assign fall = ~lineIn & prevLine;

    always_comb begin
        for (int i = 0; i < N; i++) begin
            if (!lineEnable[i]) begin
                hit[i] = 1'b0;
            end else if (!singleMode[i]) begin
                hit[i] = rise[i] | fall[i];
            end else begin
                hit[i] = risingSel[i] ? rise[i] : fall[i];
            end
        end
    end

endmodule

/* logic/wud_ahb_phase.sv */
// AHB-Lite address-phase capture for a zero-wait slave
`timescale 1ns/1ps
module wud_ahb_phase
    import wud_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // Address phase
    input  wire logic              hsel,
    input  wire logic [ADDR_W-1:0] haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic              hready,
    // Data phase view
    output logic                   dphWrite,
    output logic                   dphRead,
    output logic      [IDX_W:0]    dphIndex
);

    logic takeAddr;

    // Only NONSEQ/SEQ transfers count; IDLE and BUSY are ignored
    assign takeAddr = hsel & htrans[1] & hready;

    always_ff @(posedge clk) begin
        if (rst) begin
            dphWrite <= 1'b0;
            dphRead  <= 1'b0;
            dphIndex <= '0;
        end else if (hready) begin
            dphWrite <= takeAddr & hwrite;
            dphRead  <= takeAddr & ~hwrite;
            dphIndex <= wud_index(haddr);
        end
    end

endmodule

/* logic/wud_top.sv */
// Wake-up interrupt detector: registers, flags and request output
//
// Notes on behaviour
// - Eight read-only pending flags, one per line, cleared to zero by reset.
// - Mode bit 0 detects both edges; 1 detects a single edge; resets 0.
// - Direction bit in single mode: 0 falling, 1 rising; resets 0.
// - Enable bit 0 stops its line from raising a wake-up request.
`timescale 1ns/1ps
module wud_top
    import wud_pkg::*;
#(
    parameter int N = NUM_LINES
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // AHB-Lite slave
    input  wire logic              hsel,
    input  wire logic [ADDR_W-1:0] haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic                   hreadyout,
    output logic      [31:0]       hrdata,
    output logic                   hresp,
    // Wake-up lines
    input  wire logic [N-1:0]      wakeupInputLine,
    // To the processor
    output logic                   wakeupReq,
    output logic      [N-1:0]      pendingFlag,
    output logic [MASK_BITS-1:0]   maskEnable
);

    // ************************************************
    // Bus phase tracking
    // ************************************************
    logic              dphWrite;
    logic              dphRead;
    logic [IDX_W:0]    dphIndex;
    logic              wrValid;
    logic [IDX_W-1:0]  wrIdx;
    logic [REG_W-1:0]  wrData;

    wud_ahb_phase u_phase (
        .clk      (clk),
        .rst      (rst),
        .hsel     (hsel),
        .haddr    (haddr),
        .htrans   (htrans),
        .hwrite   (hwrite),
        .hready   (hready),
        .dphWrite (dphWrite),
        .dphRead  (dphRead),
        .dphIndex (dphIndex)
    );

    // Zero wait states; every access, mapped or not, answers OKAY
    assign hreadyout = 1'b1;
    assign hresp     = HRESP_OKAY;
    assign wrValid   = dphWrite & dphIndex[IDX_W];
    assign wrIdx     = dphIndex[IDX_W-1:0];
    assign wrData    = hwdata[REG_W-1:0];

    // ************************************************
    // Configuration registers
    // ************************************************
    logic [REG_W-1:0]     detectMode;
    logic [REG_W-1:0]     edgeDir;
    logic [REG_W-1:0]     inputEnable;
    logic [MASK_BITS-1:0] intMaskFive;

    always_ff @(posedge clk) begin
        if (rst) begin
            detectMode <= RST_DETECT_MODE;
        end else if (wrValid && wrIdx == IDX_DETECT_MODE) begin
            detectMode <= wrData;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            edgeDir <= RST_EDGE_DIR;
        end else if (wrValid && wrIdx == IDX_EDGE_DIR) begin
            edgeDir <= wrData;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            inputEnable <= RST_INPUT_ENABLE;
        end else if (wrValid && wrIdx == IDX_INPUT_ENABLE) begin
            inputEnable <= wrData;
        end
    end

    // Bit 7 of the written byte is dropped and always reads zero
    always_ff @(posedge clk) begin
        if (rst) begin
            intMaskFive <= RST_INT_MASK_FIVE;
        end else if (wrValid && wrIdx == IDX_INT_MASK_FIVE) begin
            intMaskFive <= wrData[MASK_BITS-1:0];
        end
    end

    assign maskEnable = intMaskFive;

    // ************************************************
    // Edge detection and pending flags
    // ************************************************
    logic [N-1:0] rise;
    logic [N-1:0] fall;
    logic [N-1:0] hit;
    logic [N-1:0] flagClear;
    logic [N-1:0] next_flags;

    wud_edge_detect #(
        .N (N)
    ) u_detect (
        .clk        (clk),
        .rst        (rst),
        .lineIn     (wakeupInputLine),
        .singleMode (detectMode[N-1:0]),
        .risingSel  (edgeDir[N-1:0]),
        .lineEnable (inputEnable[N-1:0]),
        .rise       (rise),
        .fall       (fall),
        .hit        (hit)
    );

    // Write-one-to-clear; the flag register itself ignores writes
    assign flagClear = (wrValid && wrIdx == IDX_FLAG_CLEAR) ? wrData[N-1:0] : '0;

    // A new edge wins over a clear in the same cycle, so none is lost
    assign next_flags = (pendingFlag & ~flagClear) | hit;

    always_ff @(posedge clk) begin
        if (rst) begin
            pendingFlag <= RST_REQ_FLAGS[N-1:0];
        end else begin
            pendingFlag <= next_flags;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wakeupReq <= 1'b0;
        end else begin
            wakeupReq <= |next_flags;
        end
    end

    // ************************************************
    // Read mux
    // ************************************************
    function automatic logic [REG_W-1:0] readValue(input logic [IDX_W:0] idx);
        readValue = '0;
        if (idx[IDX_W]) begin
            unique case (idx[IDX_W-1:0])
                IDX_INT_MASK_FIVE: readValue = {1'b0, intMaskFive};
                IDX_REQ_FLAGS:     readValue = REG_W'(pendingFlag);
                IDX_DETECT_MODE:   readValue = detectMode;
                IDX_EDGE_DIR:      readValue = edgeDir;
                IDX_INPUT_ENABLE:  readValue = inputEnable;
                default:           readValue = '0;
            endcase
        end
    endfunction

    // Reads show live register state during the data phase
    // A process, not an assign, so a flag set mid-phase is seen too
    always_comb begin
        hrdata = dphRead ? {24'h000000, readValue(dphIndex)} : 32'h00000000;
    end

    // ************************************************
    // Assertions
    // ************************************************
    logic [N-1:0] bothMatch;
    logic [N-1:0] riseMatch;
    logic [N-1:0] wrongEdge;
    logic [N-1:0] blocked;

    assign bothMatch = inputEnable[N-1:0] & ~detectMode[N-1:0] & (rise | fall);
    assign riseMatch = inputEnable[N-1:0] & detectMode[N-1:0] & edgeDir[N-1:0] & rise;
    assign wrongEdge = inputEnable[N-1:0] & detectMode[N-1:0] & ~edgeDir[N-1:0] & rise
                       & ~pendingFlag;
    assign blocked   = ~inputEnable[N-1:0] & (rise | fall) & ~pendingFlag;

    AST_FLAG_RESET: assert property (@(posedge clk)
        $past(rst) |-> pendingFlag == '0 && !wakeupReq)
        else $error("flags not zero after reset");

    AST_FLAG_HOLD: assert property (@(posedge clk) disable iff (rst)
        (hit == '0 && flagClear == '0) |=> $stable(pendingFlag))
        else $error("flag changed with no edge and no clear");

    AST_BOTH_EDGES: assert property (@(posedge clk) disable iff (rst)
        bothMatch != '0 |=> (pendingFlag & $past(bothMatch)) == $past(bothMatch))
        else $error("both-edge mode missed a transition");

    AST_RISE_ONLY: assert property (@(posedge clk) disable iff (rst)
        riseMatch != '0 |=> (pendingFlag & $past(riseMatch)) == $past(riseMatch))
        else $error("rising edge missed in single mode");

    AST_WRONG_EDGE: assert property (@(posedge clk) disable iff (rst)
        wrongEdge != '0 |=> (pendingFlag & $past(wrongEdge)) == '0)
        else $error("rising edge flagged while falling selected");

    AST_DISABLED: assert property (@(posedge clk) disable iff (rst)
        blocked != '0 |=> (pendingFlag & $past(blocked)) == '0)
        else $error("disabled line raised a flag");

    AST_MASK_RESET: assert property (@(posedge clk)
        $past(rst) |-> maskEnable == RST_INT_MASK_FIVE)
        else $error("mask not all ones after reset");

    AST_MASK_WRITE: assert property (@(posedge clk) disable iff (rst)
        (wrValid && wrIdx == IDX_INT_MASK_FIVE) |=> maskEnable == $past(hwdata[6:0]))
        else $error("mask write not stored");

    AST_MASK_BIT7: assert property (@(posedge clk) disable iff (rst)
        (dphRead && dphIndex == {1'b1, IDX_INT_MASK_FIVE}) |-> hrdata[31:7] == '0)
        else $error("unused mask bits read nonzero");

    AST_SET_WINS: assert property (@(posedge clk) disable iff (rst)
        (hit & flagClear) != '0 |=> (pendingFlag & $past(hit)) == $past(hit))
        else $error("clear beat a same-cycle edge");

    AST_REQ_FOLLOWS: assert property (@(posedge clk) disable iff (rst)
        hit != '0 |=> wakeupReq ##0 (pendingFlag != '0) [*1])
        else $error("request not raised after a match");

    AST_REQ_DROPS: assert property (@(posedge clk) disable iff (rst)
        (pendingFlag != '0 && (pendingFlag & ~flagClear) == '0 && hit == '0) |=> !wakeupReq)
        else $error("request stayed after all flags cleared");

    COV_BOTH: cover property (@(posedge clk) disable iff (rst)
        bothMatch != '0 ##1 wakeupReq);

    COV_SINGLE_FALL: cover property (@(posedge clk) disable iff (rst)
        (inputEnable[N-1:0] & detectMode[N-1:0] & ~edgeDir[N-1:0] & fall) != '0);

    COV_CLEAR: cover property (@(posedge clk) disable iff (rst)
        wakeupReq ##1 flagClear != '0 ##1 !wakeupReq);

    COV_COLLIDE: cover property (@(posedge clk) disable iff (rst)
        (hit & flagClear) != '0);

endmodule

/* verification/wud_wake_source.sv */
// Model of the external wake-up sources driving the lines
`timescale 1ns/1ps
module wud_wake_source
    import wud_pkg::*;
#(
    parameter int LAG = 1
) (
    // Clock
    input  wire logic                 clk,
    // Requested and driven levels
    input  wire logic [NUM_LINES-1:0] level,
    output logic      [NUM_LINES-1:0] line
);
    // ************************************************
    // Delay line
    // ************************************************
    // Lines change only after an edge, like a source synchronous to clk
    logic [NUM_LINES-1:0] pipe [LAG] = '{default: 8'h00};

    always @(posedge clk) begin
        pipe[0] <= level;
        for (int i = 1; i < LAG; i++) begin
            pipe[i] <= pipe[i-1];
        end
    end

    assign line = pipe[LAG-1];
endmodule

/* verification/tb.sv */
// Self-checking bench for the wake-up interrupt detector
`timescale 1ns/1ps
module tb
    import wud_pkg::*;
;
    // ************************************************
    // Signals
    // ************************************************
    logic                 clk = 1'h0;
    logic                 rst = 1'h1;
    logic                 hsel = 1'h0;
    logic [ADDR_W-1:0]    haddr = 10'h000;
    logic [1:0]           htrans = 2'h0;
    logic                 hwrite = 1'h0;
    logic [2:0]           hsize = 3'h2;
    logic [31:0]          hwdata = 32'h0;
    logic                 hready;
    logic                 hreadyout;
    logic [31:0]          hrdata;
    logic                 hresp;
    logic [NUM_LINES-1:0] srcLevel = 8'h00;
    logic [NUM_LINES-1:0] wakeupInputLine;
    logic                 wakeupReq;
    logic [NUM_LINES-1:0] pendingFlag;
    logic [MASK_BITS-1:0] maskEnable;
    int                   bad_count = 0;
    int                   comparisons = 0;
    int                   cycles = 0;

    always #25 clk = ~clk;
    assign hready = hreadyout;

    wud_top DUT (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
        .hresp(hresp), .wakeupInputLine(wakeupInputLine), .wakeupReq(wakeupReq),
        .pendingFlag(pendingFlag), .maskEnable(maskEnable));

    // Slow source: two cycles of lag
    wud_wake_source #(.LAG(2)) src (.clk(clk), .level(srcLevel), .line(wakeupInputLine));

    // ************************************************
    // Helpers
    // ************************************************
    task automatic summarize;
        $display("Counts: comparisons=%0d mismatches=%0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic xfer(input logic wr, input logic [IDX_W-1:0] idx, input logic [31:0] wd,
                        output logic [31:0] rd);
        @(posedge clk);
        hsel   <= 1'h1;
        haddr  <= {idx, 2'h0};
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        do @(posedge clk); while (hready !== 1'h1);
        hsel   <= 1'h0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'h1);
        rd = hrdata;
    endtask

    task automatic wr(input logic [IDX_W-1:0] idx, input logic [31:0] wd);
        logic [31:0] d;
        xfer(1'h1, idx, wd, d);
        // The write lands at the closing edge; settle before any output is judged
        @(negedge clk);
    endtask

    task automatic rd_chk(input logic [IDX_W-1:0] idx, input logic [31:0] exp);
        logic [31:0] d;
        xfer(1'h0, idx, 32'h0, d);
        check(d, exp);
    endtask

    // Drive the sources, then let the lag and the flag register settle
    task automatic drive(input logic [NUM_LINES-1:0] lv);
        @(posedge clk);
        srcLevel <= lv;
        repeat (5) @(posedge clk);
    endtask

    // ************************************************
    // Scenarios
    // ************************************************
    task automatic t_reset;
        rd_chk(IDX_INT_MASK_FIVE, 32'h7f);
        rd_chk(IDX_REQ_FLAGS, 32'h00);
        rd_chk(IDX_DETECT_MODE, 32'h00);
        rd_chk(IDX_EDGE_DIR, 32'h00);
        rd_chk(IDX_INPUT_ENABLE, {24'h000000, RST_INPUT_ENABLE});
        check(hresp, HRESP_OKAY);
        check(pendingFlag, 8'h00);
        check(maskEnable, 7'h7f);
        wr(IDX_REQ_FLAGS, 32'hff);
        rd_chk(IDX_REQ_FLAGS, 32'h00);
        rd_chk(8'h10, 32'h0);
        $display("Test reset values done");
    endtask

    task automatic t_mask;
        wr(IDX_INT_MASK_FIVE, 32'haa);
        rd_chk(IDX_INT_MASK_FIVE, 32'h2a);
        check(maskEnable, 7'h2a);
        wr(IDX_INT_MASK_FIVE, 32'h55);
        check(maskEnable, 7'h55);
        $display("Test mask register done");
    endtask

    task automatic t_single;
        wr(IDX_DETECT_MODE, 32'hff);
        wr(IDX_EDGE_DIR, 32'h0f);
        wr(IDX_INPUT_ENABLE, 32'hff);
        rd_chk(IDX_EDGE_DIR, 32'h0f);
        drive(8'hff);
        check(pendingFlag, 8'h0f);
        check(wakeupReq, 1'h1);
        rd_chk(IDX_REQ_FLAGS, 32'h0f);
        wr(IDX_FLAG_CLEAR, 32'hff);
        check(pendingFlag, 8'h00);
        check(wakeupReq, 1'h0);
        drive(8'h00);
        check(pendingFlag, 8'hf0);
        wr(IDX_FLAG_CLEAR, 32'hff);
        $display("Test single edge done");
    endtask

    task automatic t_both;
        wr(IDX_DETECT_MODE, 32'h00);
        wr(IDX_INPUT_ENABLE, 32'h01);
        drive(8'hff);
        check(pendingFlag, 8'h01);
        check(wakeupReq, 1'h1);
        wr(IDX_FLAG_CLEAR, 32'h01);
        drive(8'h00);
        check(pendingFlag, 8'h01);
        wr(IDX_INPUT_ENABLE, 32'h00);
        wr(IDX_FLAG_CLEAR, 32'hff);
        drive(8'hff);
        check(pendingFlag, 8'h00);
        check(wakeupReq, 1'h0);
        $display("Test both edges and enable done");
    endtask

    // ************************************************
    // Watchdog and main sequence
    // ************************************************
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            summarize();
        end
    end

    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'h0;
        t_reset();
        t_mask();
        t_single();
        t_both();
        summarize();
    end
endmodule
